// ===== rsx_alu_core.sv
`timescale 1ns/100ps
`default_nettype none
module rsx_alu_core (
   input wire logic [2:0] op,
   input wire logic dest,
   input wire logic [7:0] acc,
   input wire logic [7:0] reg_val,
   input wire logic [7:0] literal,
   input wire logic carry_in,
   output var rsx_pkg::rsx_alu_out_t alu_out
);

   logic [8:0] diff;

   always_comb begin
      diff = {1'b0, reg_val} - {1'b0, acc};
      alu_out = '0;
      alu_out.to_acc = ~dest;
      case (op)
         rsx_pkg::OP_ROTATE_RIGHT_VIA_CARRY: begin
            // Old carry enters bit 7, bit 0 leaves as carry
            alu_out.res = {carry_in, reg_val[7:1]};
            alu_out.flg.carry_flag = reg_val[0];
            alu_out.upd_c = 1'b1;
         end
         rsx_pkg::OP_SUBTRACT_ACC_FROM_REG: begin
            alu_out.res = diff[7:0];
            alu_out.flg.carry_flag = ~diff[8];
            alu_out.flg.half_carry_flag = (reg_val[3:0] >= acc[3:0]);
            alu_out.upd_c = 1'b1;
            alu_out.upd_dc = 1'b1;
            alu_out.upd_z = 1'b1;
         end
         rsx_pkg::OP_NIBBLE_EXCHANGE: begin
            alu_out.res = {reg_val[3:0], reg_val[7:4]};
         end
         rsx_pkg::OP_XOR_ACC_WITH_REG: begin
            alu_out.res = acc ^ reg_val;
            alu_out.upd_z = 1'b1;
         end
         rsx_pkg::OP_XOR_IMMEDIATE_INTO_ACC: begin
            alu_out.res = acc ^ literal;
            alu_out.upd_z = 1'b1;
            alu_out.to_acc = 1'b1;
         end
         default: begin
            alu_out.res = acc;
         end
      endcase
      alu_out.flg.zero_flag = (alu_out.res == 8'h00);
   end

endmodule : rsx_alu_core
`default_nettype wire

// ===== rsx_alu_datapath.sv
`timescale 1ns/100ps
`default_nettype none
module rsx_alu_datapath (
   input wire logic pclk,
   input wire logic presetn,
   input wire rsx_pkg::rsx_apb_req_t apb_req,
   output var rsx_pkg::rsx_apb_rsp_t apb_rsp,
   output var logic [7:0] acc_value,
   output var rsx_pkg::rsx_flags_t flags
);

   rsx_pkg::rsx_state_t st_ff;
   rsx_pkg::rsx_state_t nxt_st;
   rsx_pkg::rsx_alu_out_t alu_out;
   logic setup;
   logic access_done;
   logic cmd_write;
   logic exec;
   logic [2:0] cmd_op;
   logic cmd_dest;
   logic [rsx_pkg::RF_IDX_W-1:0] cmd_idx;
   logic [7:0] cmd_lit;
   logic [7:0] cmd_reg_val;

   function automatic logic is_rf(input logic [rsx_pkg::ADDR_W-1:0] a);
      is_rf = (a[11:9] == rsx_pkg::RF_REGION) && (a[1:0] == 2'h0);
   endfunction : is_rf

   function automatic logic [rsx_pkg::RF_IDX_W-1:0] rf_index(input logic [rsx_pkg::ADDR_W-1:0] a);
      rf_index = a[8:2];
   endfunction : rf_index

   function automatic logic op_valid(input logic [2:0] op);
      op_valid = (op <= rsx_pkg::OP_XOR_IMMEDIATE_INTO_ACC);
   endfunction : op_valid

   function automatic logic [rsx_pkg::DATA_W-1:0] status_word(input rsx_pkg::rsx_flags_t f);
      status_word = rsx_pkg::RST_WORD;
      status_word[rsx_pkg::STAT_C_BIT] = f.carry_flag;
      status_word[rsx_pkg::STAT_DC_BIT] = f.half_carry_flag;
      status_word[rsx_pkg::STAT_Z_BIT] = f.zero_flag;
   endfunction : status_word

   // APB phase decode
   assign setup = apb_req.psel && !apb_req.penable;
   assign access_done = apb_req.psel && apb_req.penable && st_ff.rsp.pready;
   assign cmd_write = access_done && apb_req.pwrite && (apb_req.paddr == rsx_pkg::OFF_CMD);

   // Command fields come straight from the write data of the command write
   assign cmd_op = apb_req.pwdata[rsx_pkg::CMD_OP_LSB +: 3];
   assign cmd_dest = apb_req.pwdata[rsx_pkg::CMD_DEST_BIT];
   assign cmd_idx = apb_req.pwdata[rsx_pkg::CMD_ADDR_LSB +: rsx_pkg::RF_IDX_W];
   assign cmd_lit = apb_req.pwdata[rsx_pkg::CMD_LIT_LSB +: 8];
   assign cmd_reg_val = st_ff.rf[cmd_idx];
   assign exec = cmd_write && op_valid(cmd_op);

   rsx_alu_core u_alu (
      .op(cmd_op),
      .dest(cmd_dest),
      .acc(st_ff.acc),
      .reg_val(cmd_reg_val),
      .literal(cmd_lit),
      .carry_in(st_ff.flg.carry_flag),
      .alu_out(alu_out)
   );

   always_comb begin
      nxt_st = st_ff;
      // Zero-wait answer: pready rises for the access cycle that follows setup
      nxt_st.rsp.pready = setup;
      if (setup) begin
         nxt_st.rsp.pslverr = 1'b0;
         nxt_st.rsp.prdata = rsx_pkg::RST_WORD;
         if (apb_req.paddr == rsx_pkg::OFF_CMD) begin
            nxt_st.rsp.prdata = st_ff.cmd;
            if (apb_req.pwrite && !op_valid(apb_req.pwdata[rsx_pkg::CMD_OP_LSB +: 3])) begin
               nxt_st.rsp.pslverr = 1'b1;
            end
         end else if (apb_req.paddr == rsx_pkg::OFF_ACC) begin
            nxt_st.rsp.prdata = {24'h00_0000, st_ff.acc};
         end else if (apb_req.paddr == rsx_pkg::OFF_STATUS) begin
            nxt_st.rsp.prdata = status_word(st_ff.flg);
         end else if (apb_req.paddr == rsx_pkg::OFF_RESULT) begin
            nxt_st.rsp.prdata = {24'h00_0000, st_ff.result};
         end else if (is_rf(apb_req.paddr)) begin
            nxt_st.rsp.prdata = {24'h00_0000, st_ff.rf[rf_index(apb_req.paddr)]};
         end else begin
            nxt_st.rsp.pslverr = 1'b1;
         end
      end
      if (access_done && apb_req.pwrite) begin
         if (apb_req.paddr == rsx_pkg::OFF_CMD) begin
            if (exec) begin
               nxt_st.cmd = apb_req.pwdata;
               nxt_st.result = alu_out.res;
               if (alu_out.to_acc) begin
                  nxt_st.acc = alu_out.res;
               end else begin
                  nxt_st.rf[cmd_idx] = alu_out.res;
               end
               if (alu_out.upd_c) begin
                  nxt_st.flg.carry_flag = alu_out.flg.carry_flag;
               end
               if (alu_out.upd_dc) begin
                  nxt_st.flg.half_carry_flag = alu_out.flg.half_carry_flag;
               end
               if (alu_out.upd_z) begin
                  nxt_st.flg.zero_flag = alu_out.flg.zero_flag;
               end
            end
         end else if (apb_req.paddr == rsx_pkg::OFF_ACC) begin
            nxt_st.acc = apb_req.pwdata[7:0];
         end else if (apb_req.paddr == rsx_pkg::OFF_STATUS) begin
            nxt_st.flg.carry_flag = apb_req.pwdata[rsx_pkg::STAT_C_BIT];
            nxt_st.flg.half_carry_flag = apb_req.pwdata[rsx_pkg::STAT_DC_BIT];
            nxt_st.flg.zero_flag = apb_req.pwdata[rsx_pkg::STAT_Z_BIT];
         end else if (is_rf(apb_req.paddr)) begin
            nxt_st.rf[rf_index(apb_req.paddr)] = apb_req.pwdata[7:0];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff <= '0;
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign apb_rsp = st_ff.rsp;
   assign acc_value = st_ff.acc;
   assign flags = st_ff.flg;

   // Checks on the datapath
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_exec_op(logic [2:0] o);
      exec && (cmd_op == o);
   endsequence

   sequence s_exec_reg_form(logic d);
      exec && (cmd_op != rsx_pkg::OP_XOR_IMMEDIATE_INTO_ACC) && (cmd_dest == d);
   endsequence

   sequence s_setup_unmapped;
      setup && (apb_req.paddr != rsx_pkg::OFF_CMD) && (apb_req.paddr != rsx_pkg::OFF_ACC)
         && (apb_req.paddr != rsx_pkg::OFF_STATUS) && (apb_req.paddr != rsx_pkg::OFF_RESULT)
         && !is_rf(apb_req.paddr);
   endsequence

   sequence s_write_to(logic [rsx_pkg::ADDR_W-1:0] a);
      setup && apb_req.pwrite && (apb_req.paddr == a) ##1 access_done;
   endsequence

   sequence s_read_of(logic [rsx_pkg::ADDR_W-1:0] a);
      setup && !apb_req.pwrite && (apb_req.paddr == a);
   endsequence

   sequence s_rf_access(logic w);
      setup && (apb_req.pwrite == w) && is_rf(apb_req.paddr);
   endsequence

   sequence s_bad_cmd_write;
      setup && apb_req.pwrite && (apb_req.paddr == rsx_pkg::OFF_CMD)
         && !op_valid(apb_req.pwdata[rsx_pkg::CMD_OP_LSB +: 3]);
   endsequence

   sequence s_unmapped_write;
      s_setup_unmapped ##0 apb_req.pwrite ##1 access_done;
   endsequence

   AST_DEST_ACC_KEEPS_RF: assert property (
      s_exec_reg_form(1'b0) |=> (st_ff.rf == $past(st_ff.rf)) && (st_ff.acc == $past(alu_out.res)))
      else $error("Destination zero touched the register file or missed the accumulator");

   AST_DEST_REG_WRITEBACK: assert property (
      s_exec_reg_form(1'b1) |=> (st_ff.rf[$past(cmd_idx)] == $past(alu_out.res)) && $stable(st_ff.acc))
      else $error("Destination one did not write back to the addressed register");

   AST_ROTATE_CARRY: assert property (
      s_exec_op(rsx_pkg::OP_ROTATE_RIGHT_VIA_CARRY)
      |=> (st_ff.result == {$past(st_ff.flg.carry_flag), $past(cmd_reg_val[7:1])})
      && (st_ff.flg.carry_flag == $past(cmd_reg_val[0]))
      && $stable(st_ff.flg.zero_flag) && $stable(st_ff.flg.half_carry_flag))
      else $error("Rotate through carry gave wrong result or flags");

   AST_SUBTRACT: assert property (
      s_exec_op(rsx_pkg::OP_SUBTRACT_ACC_FROM_REG)
      |=> (st_ff.result == 8'($past(cmd_reg_val) - $past(st_ff.acc)))
      && (st_ff.flg.half_carry_flag == ($past(cmd_reg_val[3:0]) >= $past(st_ff.acc[3:0]))))
      else $error("Subtract result or half carry wrong");

   AST_NIBBLE_EXCHANGE: assert property (
      s_exec_op(rsx_pkg::OP_NIBBLE_EXCHANGE)
      |=> (st_ff.result == {$past(cmd_reg_val[3:0]), $past(cmd_reg_val[7:4])}) && $stable(st_ff.flg))
      else $error("Nibble exchange wrong or flags changed");

   AST_XOR_REG: assert property (
      s_exec_op(rsx_pkg::OP_XOR_ACC_WITH_REG)
      |=> (st_ff.result == ($past(st_ff.acc) ^ $past(cmd_reg_val)))
      && $stable(st_ff.flg.carry_flag) && $stable(st_ff.flg.half_carry_flag))
      else $error("Register XOR wrong or carry flags changed");

   AST_XOR_IMM: assert property (
      s_exec_op(rsx_pkg::OP_XOR_IMMEDIATE_INTO_ACC)
      |=> (st_ff.acc == ($past(st_ff.acc) ^ $past(cmd_lit))) && (st_ff.rf == $past(st_ff.rf))
      && $stable(st_ff.flg.carry_flag))
      else $error("Immediate XOR did not land in the accumulator");

   AST_ZERO_FLAG: assert property (
      exec && (cmd_op != rsx_pkg::OP_ROTATE_RIGHT_VIA_CARRY) && (cmd_op != rsx_pkg::OP_NIBBLE_EXCHANGE)
      |=> st_ff.flg.zero_flag == (st_ff.result == 8'h00))
      else $error("Zero flag does not match result");

   AST_SUB_NO_BORROW: assert property (
      s_exec_op(rsx_pkg::OP_SUBTRACT_ACC_FROM_REG)
      |=> st_ff.flg.carry_flag == ($past(cmd_reg_val) >= $past(st_ff.acc)))
      else $error("Subtract carry does not reflect no borrow");

   AST_APB_UNMAPPED: assert property (
      s_setup_unmapped |=> apb_rsp.pready && apb_rsp.pslverr ##1 !apb_rsp.pready)
      else $error("Unmapped access not answered with one error cycle");

   AST_READY_PULSE: assert property (
      setup |=> apb_rsp.pready ##1 !apb_rsp.pready)
      else $error("Ready did not stand for exactly the access cycle");

   AST_READY_ONLY_AFTER_SETUP: assert property (
      !setup |=> !apb_rsp.pready)
      else $error("Ready raised without a setup cycle");

   AST_RESET_CLEAN: assert property (disable iff (1'b0)
      !presetn |=> (acc_value == rsx_pkg::RST_ACC) && (flags == '0) && (apb_rsp == '0)
      && (st_ff.cmd == rsx_pkg::RST_WORD) && (st_ff.result == rsx_pkg::RST_BYTE))
      else $error("State not cleared while reset is held");

   AST_ACC_WRITE: assert property (
      s_write_to(rsx_pkg::OFF_ACC) |=> acc_value == $past(apb_req.pwdata[7:0]))
      else $error("Accumulator write did not land");

   AST_STATUS_WRITE: assert property (
      s_write_to(rsx_pkg::OFF_STATUS)
      |=> (flags.carry_flag == $past(apb_req.pwdata[rsx_pkg::STAT_C_BIT]))
      && (flags.half_carry_flag == $past(apb_req.pwdata[rsx_pkg::STAT_DC_BIT]))
      && (flags.zero_flag == $past(apb_req.pwdata[rsx_pkg::STAT_Z_BIT])))
      else $error("Status write did not land in the flags");

   AST_RESULT_READ_ONLY: assert property (
      s_write_to(rsx_pkg::OFF_RESULT) |=> $stable(st_ff.result) && $stable(acc_value))
      else $error("Write to the result register changed state");

   AST_RF_WRITE: assert property (
      s_rf_access(1'b1) ##1 access_done
      |=> st_ff.rf[$past(rf_index(apb_req.paddr))] == $past(apb_req.pwdata[7:0]))
      else $error("Register file write did not land");

   AST_BAD_CMD_REFUSED: assert property (
      s_bad_cmd_write |=> apb_rsp.pready && apb_rsp.pslverr
      ##1 $stable(st_ff.cmd) && $stable(acc_value) && $stable(flags)
      && $stable(st_ff.result) && (st_ff.rf == $past(st_ff.rf)))
      else $error("Refused command changed the datapath state");

   AST_UNMAPPED_WRITE_IGNORED: assert property (
      s_unmapped_write |=> $stable(acc_value) && $stable(flags) && $stable(st_ff.cmd)
      && (st_ff.rf == $past(st_ff.rf)))
      else $error("Unmapped write changed the datapath state");

   AST_CMD_READ: assert property (
      s_read_of(rsx_pkg::OFF_CMD) |=> apb_rsp.prdata == $past(st_ff.cmd))
      else $error("Command read returned the wrong word");

   AST_ACC_READ: assert property (
      s_read_of(rsx_pkg::OFF_ACC) |=> !apb_rsp.pslverr && (apb_rsp.prdata == {24'h00_0000, $past(acc_value)}))
      else $error("Accumulator read returned the wrong word");

   AST_STATUS_READ: assert property (
      s_read_of(rsx_pkg::OFF_STATUS) |=> apb_rsp.prdata == status_word($past(flags)))
      else $error("Status read returned the wrong word");

   AST_RESULT_READ: assert property (
      s_read_of(rsx_pkg::OFF_RESULT) |=> apb_rsp.prdata == {24'h00_0000, $past(st_ff.result)})
      else $error("Result read returned the wrong word");

   AST_RF_READ: assert property (
      s_rf_access(1'b0)
      |=> apb_rsp.prdata == {24'h00_0000, $past(st_ff.rf[rf_index(apb_req.paddr)])})
      else $error("Register file read returned the wrong word");

   AST_EXEC_RECORDS: assert property (
      exec
      |=> (st_ff.cmd == $past(apb_req.pwdata)) && (st_ff.result == $past(alu_out.res)))
      else $error("Executed command or its result not recorded");

   AST_QUIET_BETWEEN_WRITES: assert property (
      !(access_done && apb_req.pwrite)
      |=> $stable(acc_value) && $stable(flags) && $stable(st_ff.cmd) && $stable(st_ff.result))
      else $error("State changed without a completed write");

endmodule : rsx_alu_datapath
`default_nettype wire

// ===== rsx_alu_datapath_bench.sv
`timescale 1ns/100ps
`default_nettype none
module rsx_alu_datapath_bench;
   logic pclk;
   logic presetn;
   rsx_pkg::rsx_apb_req_t req;
   rsx_pkg::rsx_apb_rsp_t rsp;
   logic [7:0] acc_value;
   rsx_pkg::rsx_flags_t flags;
   int errors;
   int checks;
   int cyc = 0;
   int m_rf [128];
   int m_acc, m_c, m_dc, m_z, m_res;
   logic [31:0] m_cmd;

   rsx_alu_datapath dut_u (
      .pclk(pclk),
      .presetn(presetn),
      .apb_req(req),
      .apb_rsp(rsp),
      .acc_value(acc_value),
      .flags(flags)
   );

   always #5 pclk = ~pclk;

   task automatic report_and_stop;
      $display("Counts: checks=%0d errors=%0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   // Bounded run length
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         errors++;
         report_and_stop();
      end
   end

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   // One APB transfer, idle cycle before setup
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
      @(posedge pclk);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= wr;
      req.paddr <= a;
      req.pwdata <= wd;
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (rsp.pready !== 1'b1);
      rd = rsp.prdata;
      err = rsp.pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic exp_err);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
      chk("pslverr_wr", {31'h0, exp_err}, {31'h0, err});
   endtask : wr

   task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
      logic [31:0] d;
      logic err;
      apb(1'b0, a, 32'h0, d, err);
      chk(nm, exp, d);
      chk("pslverr_rd", {31'h0, exp_err}, {31'h0, err});
   endtask : rd

   task automatic run_cmd(input int op, input int d, input int idx, input int lit);
      int r;
      int res;
      m_cmd = 32'(op) | (32'(d) << 3) | (32'(idx) << 4) | (32'(lit) << 16);
      wr(12'h000, m_cmd, 1'b0);
      r = m_rf[idx];
      res = 0;
      case (op)
         0: begin
            res = (m_c << 7) | (r >> 1);
            m_c = r & 1;
         end
         1: begin
            res = (r - m_acc) & 255;
            m_c = (r >= m_acc) ? 1 : 0;
            m_dc = ((r & 15) >= (m_acc & 15)) ? 1 : 0;
            m_z = (res == 0) ? 1 : 0;
         end
         2: res = ((r << 4) | (r >> 4)) & 255;
         3: begin
            res = r ^ m_acc;
            m_z = (res == 0) ? 1 : 0;
         end
         default: begin
            res = m_acc ^ lit;
            m_z = (res == 0) ? 1 : 0;
         end
      endcase
      if (op == 4 || d == 0) begin
         m_acc = res;
      end else begin
         m_rf[idx] = res;
      end
      m_res = res;
      rd("result", 12'h00C, 32'(m_res), 1'b0);
      chk("acc_port", 32'(m_acc), {24'h0, acc_value});
      chk("flag_port", 32'((m_z << 2) | (m_dc << 1) | m_c), {29'h0, flags});
      rd("acc", 12'h004, 32'(m_acc), 1'b0);
      rd("status", 12'h008, 32'((m_z << 2) | (m_dc << 1) | m_c), 1'b0);
      rd("rf", 12'(12'h200 + 4 * idx), 32'(m_rf[idx]), 1'b0);
   endtask : run_cmd

   initial begin
      int s;
      int op, d, idx, v, st;
      pclk = 1'b0;
      presetn = 1'b0;
      req = '0;
      errors = 0;
      checks = 0;
      m_acc = 0; m_c = 0; m_dc = 0; m_z = 0; m_res = 0; m_cmd = 32'h0;
      foreach (m_rf[i]) m_rf[i] = 0;
      s = $urandom(32'hD8F9);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd("cmd_rst", 12'h000, 32'h0, 1'b0);
      rd("acc_rst", 12'h004, 32'h0, 1'b0);
      rd("status_rst", 12'h008, 32'h0, 1'b0);
      rd("rf_rst", 12'h3FC, 32'h0, 1'b0);
      $display("Test reset done");
      for (int i = 0; i < 60; i++) begin
         op = i % 5;
         d = $urandom_range(1, 0);
         idx = (i < 5) ? 0 : (i < 10) ? 127 : $urandom_range(127, 0);
         v = $urandom_range(255, 0);
         st = $urandom_range(7, 0);
         wr(12'h004, 32'(v), 1'b0);
         m_acc = v;
         v = (i % 10 == 1) ? m_acc : $urandom_range(255, 0);
         wr(12'(12'h200 + 4 * idx), 32'(v), 1'b0);
         m_rf[idx] = v;
         wr(12'h008, 32'(st), 1'b0);
         m_c = st & 1; m_dc = (st >> 1) & 1; m_z = (st >> 2) & 1;
         run_cmd(op, d, idx, (i % 7 == 4) ? m_acc : $urandom_range(255, 0));
      end
      $display("Test operations done");
      for (int k = 5; k < 8; k++) begin
         wr(12'h000, 32'(k) | 32'h0000_0010, 1'b1);
         rd("cmd_keep", 12'h000, m_cmd, 1'b0);
         rd("acc_keep", 12'h004, 32'(m_acc), 1'b0);
      end
      wr(12'h00C, 32'h0000_00A5, 1'b0);
      wr(12'h010, 32'h0000_005A, 1'b1);
      rd("acc_unmapped", 12'h004, 32'(m_acc), 1'b0);
      rd("result_ro", 12'h00C, 32'(m_res), 1'b0);
      rd("unmapped", 12'h010, 32'h0, 1'b1);
      rd("unaligned", 12'h002, 32'h0, 1'b1);
      $display("Test refusals done");
      report_and_stop();
   end
endmodule : rsx_alu_datapath_bench
`default_nettype wire

// ===== rsx_pkg.sv
`default_nettype none
package rsx_pkg;

   // APB geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int RF_DEPTH = 128;
   localparam int RF_IDX_W = 7;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] OFF_CMD = 12'h000;
   localparam logic [ADDR_W-1:0] OFF_ACC = 12'h004;
   localparam logic [ADDR_W-1:0] OFF_STATUS = 12'h008;
   localparam logic [ADDR_W-1:0] OFF_RESULT = 12'h00C;
   localparam logic [ADDR_W-1:0] OFF_RF_BASE = 12'h200;
   localparam logic [2:0] RF_REGION = 3'h1;

   // Command word fields
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_DEST_BIT = 3;
   localparam int CMD_ADDR_LSB = 4;
   localparam int CMD_LIT_LSB = 16;

   // Status register bit positions
   localparam int STAT_C_BIT = 0;
   localparam int STAT_DC_BIT = 1;
   localparam int STAT_Z_BIT = 2;

   // Reset values
   localparam logic [7:0] RST_ACC = 8'h00;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

   typedef enum logic [2:0] {
      OP_ROTATE_RIGHT_VIA_CARRY,
      OP_SUBTRACT_ACC_FROM_REG,
      OP_NIBBLE_EXCHANGE,
      OP_XOR_ACC_WITH_REG,
      OP_XOR_IMMEDIATE_INTO_ACC
   } rsx_op_t;

   typedef struct packed {
      logic zero_flag;
      logic half_carry_flag;
      logic carry_flag;
   } rsx_flags_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } rsx_apb_req_t;

   typedef struct packed {
      logic [DATA_W-1:0] prdata;
      logic pready;
      logic pslverr;
   } rsx_apb_rsp_t;

   typedef struct packed {
      logic [7:0] res;
      rsx_flags_t flg;
      logic upd_c;
      logic upd_dc;
      logic upd_z;
      logic to_acc;
   } rsx_alu_out_t;

   typedef struct packed {
      logic [RF_DEPTH-1:0][7:0] rf;
      logic [7:0] acc;
      rsx_flags_t flg;
      logic [DATA_W-1:0] cmd;
      logic [7:0] result;
      rsx_apb_rsp_t rsp;
   } rsx_state_t;

endpackage : rsx_pkg
`default_nettype wire
